// >>> src/sps_status.sv
`timescale 1ns/1ps
`include "sps_consts.svh"

// Contract
// - Status reflects force-register writes and live socket pin levels.
// - Card voltage and type bits change only at interrogation or on a force write; otherwise hold.
// - Detect pin changes during identification do not change detect bits.
// - Bits 31 and 30 always read zero.
// - Bits 29 and 28 read one unless overridden by a force write.
// - Bits 27 to 14 always read zero.
// - Bits 13 to 10 report card support for Y, X, 3.3 and 5 V.
// - Bit 9 flags an invalid power request; resets to zero.
// - Bit 8 flags possible data loss on removal; resets to zero.
// - Bit 7 flags unrecognised card; frozen until valid card or force write; resets zero.
// - Bit 6 shows the card interrupt/ready pin level.
// - Bit 5 shows CardBus card; changes only at interrogation or force write.
// - Bit 4 shows 16-bit card; changes only at interrogation or force write.
// - Bit 3 shows socket power state; taken straight from socket_power_state, with no register and no reset here.
// - Bit 2 mirrors detect pin B; high means no card.
// - Bit 1 mirrors detect pin A; high means no card.
// - Bit 0 mirrors the status-change pin level.
// - Read-only status register sits at offset 08h.
// - Force writes load voltage, type, bad-request, loss and not-card bits.
// - Force writes to power, detect and status-change leave live bits alone.
module sps_status (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Socket pins (asynchronous)
  input wire logic card_irq_pin,
  input wire logic detect_pin_a,
  input wire logic detect_pin_b,
  input wire logic status_change_pin,
  // Interrogation and power logic (same clock)
  input wire logic identify_busy,
  input wire logic interrogation_done,
  input wire logic [3:0] learned_card_volts,
  input wire logic learned_cardbus,
  input wire logic learned_sixteen_bit,
  input wire logic learned_unrecognised,
  input wire logic socket_power_state,
  input wire logic invalid_power_request_set,
  input wire logic removal_data_loss_set,
  // Force events routed to the event register
  output logic [3:0] force_event_pulse,
  output logic force_interrogate_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  wire [3:0] pin_raw = {card_irq_pin, detect_pin_b, detect_pin_a, status_change_pin};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta_q <= `SPS_RST_PINS;
      pin_sync_q <= `SPS_RST_PINS;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode, answer after one wait state
  function automatic sps_pkg::sps_acc_t decode(input logic [7:0] a);
    case (a)
      `SPS_OFF_STATE: decode = sps_pkg::SPS_ACC_STATE;
      `SPS_OFF_FORCE: decode = sps_pkg::SPS_ACC_FORCE;
      default: decode = sps_pkg::SPS_ACC_NONE;
    endcase
  endfunction

  logic ack_q;
  wire sps_pkg::sps_acc_t acc = decode(avs_address);
  wire req = avs_read | avs_write;
  wire take = req & ack_q;
  // Force register is write-only; bytes must be enabled to have effect
  wire force_wr = take & avs_write & (acc == sps_pkg::SPS_ACC_FORCE);
  wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] fw = avs_writedata & wmask;
  wire [31:0] fsel = wmask;

  // One wait state per access keeps readdata registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end
  assign avs_waitrequest = req & ~ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Stored status fields
  logic [1:0] sock_q;
  logic [3:0] card_v_q;
  logic bad_q;
  logic loss_q;
  logic notcard_q;
  logic cb_q;
  logic sb_q;
  logic [1:0] cd_q;

  wire [1:0] sock_d = (force_wr)
    ? ((fw[`SPS_B_F_SOCK_3V3:`SPS_B_F_SOCK_5V0] & fsel[`SPS_B_F_SOCK_3V3:`SPS_B_F_SOCK_5V0])
       | (sock_q & ~fsel[`SPS_B_F_SOCK_3V3:`SPS_B_F_SOCK_5V0]))
    : sock_q;
  wire [3:0] fcv = fsel[`SPS_B_CARD_Y:`SPS_B_CARD_5V0];
  // A force write beats an interrogation update in the same cycle
  wire [3:0] card_v_d = (force_wr & |fcv)
    ? ((fw[`SPS_B_CARD_Y:`SPS_B_CARD_5V0] & fcv) | (card_v_q & ~fcv))
    : (interrogation_done ? learned_card_volts : card_v_q);
  wire f_bad = force_wr & fsel[`SPS_B_BADREQ];
  wire f_loss = force_wr & fsel[`SPS_B_LOSS];
  wire f_nc = force_wr & fsel[`SPS_B_NOTCARD];
  wire f_cb = force_wr & fsel[`SPS_B_CB];
  wire f_sb = force_wr & fsel[`SPS_B_16];
  // Hardware sets win over a force clear of the same bit
  wire bad_d = invalid_power_request_set | (f_bad ? fw[`SPS_B_BADREQ] : bad_q);
  wire loss_d = removal_data_loss_set | (f_loss ? fw[`SPS_B_LOSS] : loss_q);
  // Not-card only moves on a force write or an interrogation that found a valid card or a new bad one
  wire nc_d = f_nc ? fw[`SPS_B_NOTCARD]
    : (interrogation_done ? learned_unrecognised : notcard_q);
  wire cb_d = f_cb ? fw[`SPS_B_CB] : (interrogation_done ? learned_cardbus : cb_q);
  wire sb_d = f_sb ? fw[`SPS_B_16]
    : (interrogation_done ? learned_sixteen_bit : sb_q);
  // Detect levels freeze while the interrogation drives the detect pins
  wire [1:0] cd_d = identify_busy ? cd_q : pin_sync_q[2:1];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sock_q <= `SPS_RST_SOCK;
      card_v_q <= `SPS_RST_CARD;
      bad_q <= 1'b0;
      loss_q <= 1'b0;
      notcard_q <= 1'b0;
      cb_q <= 1'b0;
      sb_q <= 1'b0;
      cd_q <= `SPS_RST_CD;
    end else begin
      sock_q <= sock_d;
      card_v_q <= card_v_d;
      bad_q <= bad_d;
      loss_q <= loss_d;
      notcard_q <= nc_d;
      cb_q <= cb_d;
      sb_q <= sb_d;
      cd_q <= cd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and read path
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0;
    status_word[`SPS_B_SOCK_3V3:`SPS_B_SOCK_5V0] = sock_q;
    status_word[`SPS_B_CARD_Y:`SPS_B_CARD_5V0] = card_v_q;
    status_word[`SPS_B_BADREQ] = bad_q;
    status_word[`SPS_B_LOSS] = loss_q;
    status_word[`SPS_B_NOTCARD] = notcard_q;
    status_word[`SPS_B_IRQ] = pin_sync_q[3];
    status_word[`SPS_B_CB] = cb_q;
    status_word[`SPS_B_16] = sb_q;
    status_word[`SPS_B_PWR] = socket_power_state;
    status_word[`SPS_B_CDB] = cd_q[1];
    status_word[`SPS_B_CDA] = cd_q[0];
    status_word[`SPS_B_STS] = pin_sync_q[0];
  end

  wire rd_state = avs_read & ~ack_q & (acc == sps_pkg::SPS_ACC_STATE);
  wire rd_bad = req & ~ack_q & (acc == sps_pkg::SPS_ACC_NONE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
      force_event_pulse <= 4'h0;
      force_interrogate_pulse <= 1'b0;
    end else begin
      avs_readdata <= rd_state ? status_word : 32'h0;
      avs_response <= (req & ~ack_q) ? (rd_bad ? 2'h3 : 2'h0) : avs_response;
      force_event_pulse <= force_wr ? (fw[3:0] & fsel[3:0]) : 4'h0;
      force_interrogate_pulse <= force_wr & fw[`SPS_B_F_TEST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Edges since reset; the pin checks look back into the synchroniser
  // and must not see the reset values still in flight
  logic [1:0] rst_age_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_age_q <= 2'h0;
    end else if (rst_age_q != 2'h3) begin
      rst_age_q <= rst_age_q + 2'h1;
    end
  end

  property p_rsvd_zero;
    @(posedge sys_clk) disable iff (rst) status_word[27:14] == 14'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits nonzero");

  property p_future_zero;
    @(posedge sys_clk) disable iff (rst) status_word[31:30] == 2'h0;
  endproperty
  a_future_zero: assert property (p_future_zero)
    else $error("future voltage bits nonzero");

  property p_detect_frozen;
    @(posedge sys_clk) disable iff (rst) identify_busy |=> $stable(cd_q);
  endproperty
  a_detect_frozen: assert property (p_detect_frozen)
    else $error("detect bit moved while busy");

  property p_card_hold;
    @(posedge sys_clk) disable iff (rst)
      !interrogation_done && !force_wr |=> $stable(card_v_q) && $stable(cb_q) && $stable(sb_q);
  endproperty
  a_card_hold: assert property (p_card_hold)
    else $error("card fields changed unprompted");

  property p_card_load;
    @(posedge sys_clk) disable iff (rst)
      interrogation_done && !force_wr |=> card_v_q == $past(learned_card_volts);
  endproperty
  a_card_load: assert property (p_card_load)
    else $error("card voltages not learned");

  property p_card_force;
    @(posedge sys_clk) disable iff (rst)
      force_wr && (&fcv) |=> card_v_q == $past(fw[`SPS_B_CARD_Y:`SPS_B_CARD_5V0]);
  endproperty
  a_card_force: assert property (p_card_force)
    else $error("card voltages not forced");

  property p_sock_hold;
    @(posedge sys_clk) disable iff (rst) !force_wr |=> $stable(sock_q);
  endproperty
  a_sock_hold: assert property (p_sock_hold)
    else $error("socket capability moved");

  property p_bad_set;
    @(posedge sys_clk) disable iff (rst) invalid_power_request_set |=> status_word[9];
  endproperty
  a_bad_set: assert property (p_bad_set)
    else $error("bad request not flagged");

  property p_bad_force;
    @(posedge sys_clk) disable iff (rst)
      f_bad && !invalid_power_request_set |=> bad_q == $past(fw[`SPS_B_BADREQ]);
  endproperty
  a_bad_force: assert property (p_bad_force)
    else $error("bad request not forced");

  property p_loss_set;
    @(posedge sys_clk) disable iff (rst) removal_data_loss_set |=> status_word[8];
  endproperty
  a_loss_set: assert property (p_loss_set)
    else $error("data loss not flagged");

  property p_nc_hold;
    @(posedge sys_clk) disable iff (rst) !interrogation_done && !f_nc |=> $stable(notcard_q);
  endproperty
  a_nc_hold: assert property (p_nc_hold)
    else $error("not-card bit moved unprompted");

  property p_cb_load;
    @(posedge sys_clk) disable iff (rst)
      interrogation_done && !f_cb |=> cb_q == $past(learned_cardbus);
  endproperty
  a_cb_load: assert property (p_cb_load)
    else $error("cardbus type not learned");

  property p_sb_load;
    @(posedge sys_clk) disable iff (rst)
      interrogation_done && !f_sb |=> sb_q == $past(learned_sixteen_bit);
  endproperty
  a_sb_load: assert property (p_sb_load)
    else $error("sixteen-bit type not learned");

  sequence s_pin_rise;
    !pin_raw[0] ##1 pin_raw[0] [*3];
  endsequence
  property p_sts_follow;
    @(posedge sys_clk) disable iff (rst) s_pin_rise |-> status_word[0];
  endproperty
  a_sts_follow: assert property (p_sts_follow)
    else $error("status-change level late");

  property p_sts_level;
    @(posedge sys_clk) disable iff (rst)
      rst_age_q >= 2'h2 |-> status_word[`SPS_B_STS] == $past(pin_raw[0], 2);
  endproperty
  a_sts_level: assert property (p_sts_level)
    else $error("status-change level mismatch");

  property p_irq_level;
    @(posedge sys_clk) disable iff (rst)
      rst_age_q >= 2'h2 |-> status_word[`SPS_B_IRQ] == $past(pin_raw[3], 2);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq level mismatch");

  property p_detect_b;
    @(posedge sys_clk) disable iff (rst) rst_age_q == 2'h3 && !$past(identify_busy)
      |-> status_word[`SPS_B_CDB] == $past(pin_raw[2], 3);
  endproperty
  a_detect_b: assert property (p_detect_b)
    else $error("detect pin b level mismatch");

  property p_detect_a;
    @(posedge sys_clk) disable iff (rst) rst_age_q == 2'h3 && !$past(identify_busy)
      |-> status_word[`SPS_B_CDA] == $past(pin_raw[1], 3);
  endproperty
  a_detect_a: assert property (p_detect_a)
    else $error("detect pin a level mismatch");

  property p_pwr_level;
    @(posedge sys_clk) disable iff (rst) status_word[`SPS_B_PWR] == socket_power_state;
  endproperty
  a_pwr_level: assert property (p_pwr_level)
    else $error("power state mismatch");

  sequence s_state_read;
    avs_read && !ack_q && acc == sps_pkg::SPS_ACC_STATE;
  endsequence
  property p_state_read;
    @(posedge sys_clk) disable iff (rst)
      s_state_read |=> avs_readdata == $past(status_word) && !avs_waitrequest;
  endproperty
  a_state_read: assert property (p_state_read)
    else $error("status read data wrong");

  property p_unmapped;
    @(posedge sys_clk) disable iff (rst) req && !ack_q && acc == sps_pkg::SPS_ACC_NONE
      |=> avs_response == 2'h3 && avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_intg_pulse;
    @(posedge sys_clk) disable iff (rst) force_wr && fw[`SPS_B_F_TEST] |=> force_interrogate_pulse;
  endproperty
  a_intg_pulse: assert property (p_intg_pulse)
    else $error("interrogate pulse missing");

  property p_no_pulse;
    @(posedge sys_clk) disable iff (rst) !force_wr |=> force_event_pulse == 4'h0;
  endproperty
  a_no_pulse: assert property (p_no_pulse)
    else $error("event pulse without force write");

  property p_force_live;
    @(posedge sys_clk) disable iff (rst)
      force_wr && fw[0] && !identify_busy |=> force_event_pulse[0];
  endproperty
  a_force_live: assert property (p_force_live)
    else $error("force event not passed");

endmodule

// >>> src/sps_consts.svh
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// Register map (byte addresses, word aligned)
`define SPS_ADDR_W 8
`define SPS_OFF_STATE 8'h08
`define SPS_OFF_FORCE 8'h0c

// Status bit positions
`define SPS_B_SOCK_Y 31
`define SPS_B_SOCK_X 30
`define SPS_B_SOCK_3V3 29
`define SPS_B_SOCK_5V0 28
`define SPS_B_CARD_Y 13
`define SPS_B_CARD_X 12
`define SPS_B_CARD_3V3 11
`define SPS_B_CARD_5V0 10
`define SPS_B_BADREQ 9
`define SPS_B_LOSS 8
`define SPS_B_NOTCARD 7
`define SPS_B_IRQ 6
`define SPS_B_CB 5
`define SPS_B_16 4
`define SPS_B_PWR 3
`define SPS_B_CDB 2
`define SPS_B_CDA 1
`define SPS_B_STS 0

// Socket capability override and interrogate bits in the force register
`define SPS_B_F_SOCK_3V3 29
`define SPS_B_F_SOCK_5V0 28
`define SPS_B_F_TEST 14

// Reset values
`define SPS_RST_SOCK 2'h3
`define SPS_RST_CARD 4'h0
`define SPS_RST_PINS 4'hf
`define SPS_RST_CD 2'h3

`endif

// >>> src/sps_pkg.sv
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_ACC_NONE,
    SPS_ACC_STATE,
    SPS_ACC_FORCE
  } sps_acc_t;
endpackage

// >>> dv/sps_card_model.sv
`timescale 1ns/1ps

// Removable card at the socket; the bench says whether one is seated and sets its irq and status-change levels
module sps_card_model (
  // Control from the bench
  input wire logic sys_clk,
  input wire logic inserted,
  input wire logic irq_level,
  input wire logic sts_level,
  // Socket pins
  output logic card_irq_pin,
  output logic detect_pin_a,
  output logic detect_pin_b,
  output logic status_change_pin
);
  // Detect pins sit on pull-ups, so an empty socket reads high
  // Card-driven pins fall to their pull-downs when no card is seated
  always_ff @(posedge sys_clk) begin
    detect_pin_a <= !inserted;
    detect_pin_b <= !inserted;
    card_irq_pin <= inserted & irq_level;
    status_change_pin <= inserted & sts_level;
  end
endmodule

// >>> dv/tb_socket_present_state.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end

module tb_socket_present_state;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] avs_response, rs;
  logic card_irq_pin, detect_pin_a, detect_pin_b, status_change_pin;
  logic identify_busy, done, cb, sb, unrec, pwr, inv_set, loss_set;
  logic inserted, irq_level, sts_level, f_intg;
  logic [3:0] volts, f_ev, be;
  int err_count, checked;

  sps_status u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .card_irq_pin(card_irq_pin), .detect_pin_a(detect_pin_a),
    .detect_pin_b(detect_pin_b), .status_change_pin(status_change_pin),
    .identify_busy(identify_busy), .interrogation_done(done),
    .learned_card_volts(volts), .learned_cardbus(cb), .learned_sixteen_bit(sb),
    .learned_unrecognised(unrec), .socket_power_state(pwr),
    .invalid_power_request_set(inv_set), .removal_data_loss_set(loss_set),
    .force_event_pulse(f_ev), .force_interrogate_pulse(f_intg));

  sps_card_model u_card (.sys_clk(sys_clk), .inserted(inserted), .irq_level(irq_level),
    .sts_level(sts_level), .card_irq_pin(card_irq_pin), .detect_pin_a(detect_pin_a),
    .detect_pin_b(detect_pin_b), .status_change_pin(status_change_pin));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wait_cy(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One Avalon access; the request stands until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        err_count++;
        conclude();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(1'b0, 8'h08, 32'h0);
    `CHK("reset status", 32'h3000_0006, rd)
    `CHK("reset resp", 2'h0, rs)
  endtask

  task automatic t_pins();
    inserted <= 1'b1;
    irq_level <= 1'b1;
    sts_level <= 1'b1;
    pwr <= 1'b1;
    wait_cy(5);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("live pins", 32'h3000_0049, rd)
  endtask

  // Card pulled while identification runs: detect bits must stay put
  task automatic t_identify();
    identify_busy <= 1'b1;
    inserted <= 1'b0;
    wait_cy(5);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("frozen detect", 32'h3000_0008, rd)
    identify_busy <= 1'b0;
    wait_cy(5);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("empty socket", 32'h3000_000e, rd)
  endtask

  task automatic t_interrog();
    inserted <= 1'b1;
    {volts, cb, sb, unrec} <= {4'ha, 1'b1, 1'b0, 1'b1};
    wait_cy(5);
    done <= 1'b1;
    @(posedge sys_clk);
    done <= 1'b0;
    {volts, cb, sb, unrec} <= {4'h5, 1'b0, 1'b1, 1'b0};
    wait_cy(2);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("learned", 32'h3000_28e9, rd)
  endtask

  task automatic t_sticky();
    inv_set <= 1'b1;
    loss_set <= 1'b1;
    @(posedge sys_clk);
    inv_set <= 1'b0;
    loss_set <= 1'b0;
    wait_cy(2);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("error flags", 32'h3000_2be9, rd)
  endtask

  task automatic t_force();
    bus(1'b1, 8'h0c, 32'h0000_141f);
    @(negedge sys_clk);
    `CHK("event pulse", 4'hf, f_ev)
    bus(1'b0, 8'h08, 32'h0);
    `CHK("forced", 32'h0000_1459, rd)
    bus(1'b1, 8'h0c, 32'h3000_4000);
    @(negedge sys_clk);
    `CHK("interrogate pulse", 1'b1, f_intg)
    `CHK("no event", 4'h0, f_ev)
    bus(1'b1, 8'h08, 32'hffff_ffff);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("read only", 32'h3000_0049, rd)
    bus(1'b0, 8'h0c, 32'h0);
    `CHK("force readback", 32'h0, rd)
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped resp", 2'h3, rs)
    // Only the low lane enabled: voltage bits above it must keep their value
    be <= 4'h1;
    bus(1'b1, 8'h0c, 32'hffff_ffff);
    be <= 4'hf;
    bus(1'b0, 8'h08, 32'h0);
    `CHK("lane masked force", 32'h3000_00f9, rd)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    checked = 0;
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {identify_busy, done, cb, sb, unrec, pwr, inv_set, loss_set} = '0;
    {inserted, irq_level, sts_level, volts} = '0;
    be = 4'hf;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    wait_cy(4);
    t_reset();
    t_pins();
    t_identify();
    t_interrog();
    t_sticky();
    t_force();
    conclude();
  end
endmodule
